/* inc/rlk_pkg.sv */
/*
 * Shared constants and state types for the random-lock serial link:
 * frame layout, sync payload, wake-up length and lock qualification.
 * Assumes both ends run on one clock, one serial bit per enabled cycle.
 */
`default_nettype none

package rlk_pkg;

    // =========================================================================
    // Frame layout
    // =========================================================================
    localparam int              FRAME_BITS   = 12;
    localparam int              PAYLOAD_BITS = 10;
    localparam logic [3:0]      FRAME_LAST   = 4'hB;
    localparam logic [3:0]      RCLK_FALL    = 4'h5;
    localparam logic            START_BIT    = 1'b1;
    localparam logic            STOP_BIT     = 1'b0;
    // Six ones then six zeros on the line, start and stop included.
    localparam logic [9:0]      SYNC_PAYLOAD = 10'h01F;

    // =========================================================================
    // Timing counts in frames (one frame is twelve enabled cycles) and FIFO depth in words
    // =========================================================================
    localparam logic [8:0]      INIT_FRAMES    = 9'h1FE;
    localparam logic [2:0]      CONFIRM_FRAMES = 3'h4;
    localparam int              FIFO_DEPTH     = 8;

    // =========================================================================
    // State types
    // =========================================================================
    typedef enum logic [1:0] {SER_SLEEP, SER_INIT, SER_RUN} rlk_ser_state_t;
    typedef enum logic [1:0] {DES_SLEEP, DES_SEARCH, DES_LOCKED, DES_HOLD} rlk_des_state_t;

endpackage : rlk_pkg

`default_nettype wire

/* inc/rlk_link_if.sv */
/*
 * Serial line between the serializer end and the deserializer end.
 * Assumes a released line reads low; no high impedance is modelled.
 */
`timescale 1ns/1ps
`default_nettype none

interface rlk_link_if;
    logic ser_line_out;
    logic ser_line_oe;
    logic line_level;

    // A line nobody drives settles low through its termination.
    assign line_level = ser_line_oe & ser_line_out;

    modport ser_end (output ser_line_out, output ser_line_oe);
    modport des_end (input line_level);
endinterface : rlk_link_if

`default_nettype wire

/* logic/rlk_ser.sv */
/*
 * Serializer end: an input word FIFO and the framing transmitter.
 * Assumes the deserializer samples the line once per enabled cycle.
 */
`timescale 1ns/1ps
`default_nettype none

// =============================================================================
// Word FIFO
// =============================================================================
module rlk_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    output logic      [WIDTH-1:0] rd_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("rlk_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } rlk_fifo_state_t;

    rlk_fifo_state_t q;
    rlk_fifo_state_t d;
    logic            push;
    logic            pop;

    assign wr_ready = (q.count != (AW+1)'(DEPTH));
    assign rd_valid = (q.count != '0);
    assign rd_data  = q.mem[q.rd_ptr];
    assign push     = wr_valid & wr_ready;
    assign pop      = rd_valid & rd_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr_ptr] = wr_data;
            d.wr_ptr        = q.wr_ptr + 1'b1;
        end
        if (pop) begin
            d.rd_ptr = q.rd_ptr + 1'b1;
        end
        d.count = q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end
endmodule : rlk_fifo

// =============================================================================
// Serializer
// =============================================================================
module rlk_ser
    import rlk_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clk_en,
    rlk_link_if.ser_end                  link,
    input  wire logic [PAYLOAD_BITS-1:0] parallel_data_in,
    input  wire logic                    in_valid,
    output logic                         in_ready,
    input  wire logic                    pattern_request_a,
    input  wire logic                    pattern_request_b,
    input  wire logic                    transmit_edge_select,
    input  wire logic                    sleep_request_n,
    input  wire logic                    line_driver_enable,
    output logic                         tx_running
);
    typedef struct packed {
        rlk_ser_state_t          st;
        logic [8:0]              init_cnt;
        logic [3:0]              bit_idx;
        logic [FRAME_BITS-1:0]   frame;
        logic [PAYLOAD_BITS-1:0] last;
        logic [3:0]              snap;
        logic                    parked;
    } rlk_ser_reg_t;

    rlk_ser_reg_t            q;
    rlk_ser_reg_t            d;
    logic [PAYLOAD_BITS-1:0] fifo_data;
    logic                    fifo_valid;
    logic                    fifo_pop;
    logic [3:0]              ctrl;
    logic                    boundary;
    logic                    sync_req;

    rlk_fifo #(.WIDTH(PAYLOAD_BITS), .DEPTH(DEPTH)) u_fifo (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .wr_data  (parallel_data_in),
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .rd_data  (fifo_data),
        .rd_valid (fifo_valid),
        .rd_ready (fifo_pop)
    );

    assign ctrl     = {pattern_request_a, pattern_request_b, sleep_request_n,
                       transmit_edge_select};
    assign boundary = (q.bit_idx == FRAME_LAST);
    assign sync_req = pattern_request_a | pattern_request_b;
    // Words are only taken at a frame boundary of a running link.
    assign fifo_pop = sleep_request_n & (q.st == SER_RUN) & boundary & ~sync_req;

    always_comb begin
        d = q;
        d.bit_idx = boundary ? 4'h0 : q.bit_idx + 4'h1;
        d.frame   = {1'b0, q.frame[FRAME_BITS-1:1]};
        if (!line_driver_enable && !q.parked) begin
            d.snap   = ctrl;
            d.parked = 1'b1;
        end else if (line_driver_enable && q.parked) begin
            d.parked = 1'b0;
        end
        if (boundary) begin
            unique case (q.st)
                SER_SLEEP: begin
                    d.st       = SER_INIT;
                    d.init_cnt = '0;
                    d.frame    = {STOP_BIT, SYNC_PAYLOAD, START_BIT};
                end
                SER_INIT: begin
                    d.init_cnt = q.init_cnt + 9'h001;
                    d.frame    = {STOP_BIT, SYNC_PAYLOAD, START_BIT};
                    if (q.init_cnt == INIT_FRAMES - 9'h001) begin
                        d.st = SER_RUN;
                    end
                end
                SER_RUN: begin
                    if (sync_req) begin
                        d.frame = {STOP_BIT, SYNC_PAYLOAD, START_BIT};
                    end else if (fifo_valid) begin
                        d.frame = {STOP_BIT, fifo_data, START_BIT};
                        d.last  = fifo_data;
                    end else begin
                        d.frame = {STOP_BIT, q.last, START_BIT};
                    end
                end
                default: d.st = SER_SLEEP;
            endcase
        end
        if (!sleep_request_n || (line_driver_enable && q.parked && ctrl != q.snap)) begin
            d.st      = SER_SLEEP;
            d.bit_idx = FRAME_LAST;
            d.frame   = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q         <= '0;
            q.st      <= SER_SLEEP;
            q.bit_idx <= FRAME_LAST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign link.ser_line_out = q.frame[0];
    assign link.ser_line_oe  = line_driver_enable & (q.st != SER_SLEEP);
    assign tx_running        = (q.st == SER_RUN);
endmodule : rlk_ser

`default_nettype wire

/* logic/rlk_des.sv */
/*
 * Deserializer end: random-lock clock-bit search, false-lock hold,
 * word recovery and the sleep and output-disable states.
 * Assumes one line sample per enabled cycle, twelve samples per frame.
 */
// Operation
// - Locks to random data, no sync needed.
// - Flags several possible clock-bit positions.
// - Suspect pattern keeps lock indicator high.
// - Extra low-high edge from low payload bits.
// - Pattern change drops lock, restarts search.
// - Sleep needs sleep request and enable low.
// - Sleep stops recovery, releases parallel outputs.
// - Sleep ends when sleep request goes high.
// - Both ends reinitialize after sleep.
// - Serializer sleeps whenever its request is low.
// - Serializer wake-up lasts 510 frames.
// - Lock indicator high until relocked.
// - Driver enable low releases serial line.
// - Driver re-enable resumes if controls unchanged.
// - Output enable low releases data, clock.
// - Lock indicator stays driven while disabled.
// - Data valid only while lock is low.
// - Loss of lock releases data and clock.
// - Frame: high start, ten bits, low stop.
`timescale 1ns/1ps
`default_nettype none

module rlk_des
    import rlk_pkg::*;
#(
    parameter logic [2:0] CONFIRM = CONFIRM_FRAMES
) (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clk_en,
    rlk_link_if.des_end                  link,
    input  wire logic                    sleep_request_n,
    input  wire logic                    receive_output_enable,
    output logic [PAYLOAD_BITS-1:0]      parallel_data_out,
    output logic                         data_oe,
    output logic                         recovered_clock,
    output logic                         recovered_clock_oe,
    output logic                         rx_word_valid,
    output logic                         lock_n,
    output logic                         false_lock_suspect
);
    generate
        if (CONFIRM < 3'h2) begin : g_bad
            $error("rlk_des: CONFIRM must be at least 2 frames");
        end
    endgenerate

    // =========================================================================
    // Helpers
    // =========================================================================
    function automatic logic [3:0] phase_add(input logic [3:0] a, input logic [3:0] b);
        logic [4:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s > {1'b0, FRAME_LAST}) begin
            s = s - 5'h0C;
        end
        return s[3:0];
    endfunction : phase_add

    function automatic logic [3:0] count_set(input logic [FRAME_BITS-1:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < FRAME_BITS; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : count_set

    function automatic logic [3:0] first_set(input logic [FRAME_BITS-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : first_set

    // =========================================================================
    // State
    // =========================================================================
    typedef struct packed {
        rlk_des_state_t               st;
        logic [FRAME_BITS-1:0]        sr;
        logic [3:0]                   bit_idx;
        logic [FRAME_BITS-1:0][2:0]   hits;
        logic [FRAME_BITS-1:0]        held;
        logic [3:0]                   lock_phase;
        logic [PAYLOAD_BITS-1:0]      word;
        logic                         word_valid;
        logic                         rclk;
        logic                         lock_n;
    } rlk_des_reg_t;

    rlk_des_reg_t          q;
    rlk_des_reg_t          d;
    logic [FRAME_BITS-1:0] cand;
    logic [3:0]            n_cand;
    logic                  edge_now;
    logic                  go_sleep;

    assign go_sleep = ~sleep_request_n & ~receive_output_enable;

    always_comb begin
        d            = q;
        d.word_valid = 1'b0;
        cand         = '0;
        n_cand       = 4'h0;
        edge_now     = 1'b0;
        if (go_sleep) begin
            d.st     = DES_SLEEP;
            d.hits   = '0;
            d.lock_n = 1'b1;
            d.rclk   = 1'b0;
        end else if (q.st == DES_SLEEP) begin
            // wake on request high; relock from scratch
            d.st      = DES_SEARCH;
            d.hits    = '0;
            d.bit_idx = 4'h0;
            d.lock_n  = 1'b1;
        end else begin
            d.sr      = {q.sr[FRAME_BITS-2:0], link.line_level};
            d.bit_idx = phase_add(q.bit_idx, 4'h1);
            // stop then start gives the clock-bit rising edge
            edge_now  = (d.sr[1:0] == 2'b01);
            if (!edge_now) begin
                d.hits[q.bit_idx] = 3'h0;
            end else if (q.hits[q.bit_idx] != CONFIRM) begin
                d.hits[q.bit_idx] = q.hits[q.bit_idx] + 3'h1;
            end
            for (int k = 0; k < FRAME_BITS; k++) begin
                cand[k] = (d.hits[k] == CONFIRM);
            end
            n_cand = count_set(cand);
            unique case (q.st)
                DES_SEARCH: begin
                    d.lock_n = 1'b1;
                    if (n_cand == 4'h1) begin
                        d.st         = DES_LOCKED;
                        d.lock_phase = first_set(cand);
                        d.lock_n     = 1'b0;
                    end else if (n_cand > 4'h1) begin
                        // extra edge from held payload bits
                        d.st   = DES_HOLD;
                        d.held = cand;
                    end
                end
                DES_LOCKED: begin
                    if (!cand[q.lock_phase]) begin
                        d.st     = DES_SEARCH;
                        d.lock_n = 1'b1;
                        d.rclk   = 1'b0;
                    end else if (n_cand > 4'h1) begin
                        d.st     = DES_HOLD;
                        d.held   = cand;
                        d.lock_n = 1'b1;
                        d.rclk   = 1'b0;
                    end else if (q.bit_idx == phase_add(q.lock_phase, FRAME_LAST)) begin
                        // Stop bit just landed: start sits at the far end.
                        for (int b = 0; b < PAYLOAD_BITS; b++) begin
                            d.word[b] = d.sr[FRAME_BITS-2-b];
                        end
                        d.word_valid = 1'b1;
                        d.rclk       = 1'b1;
                    end else if (q.bit_idx == phase_add(q.lock_phase, RCLK_FALL)) begin
                        d.rclk = 1'b0;
                    end
                end
                DES_HOLD: begin
                    d.lock_n = 1'b1;
                    if (cand != q.held) begin
                        d.st   = DES_SEARCH;
                        d.hits = '0;
                    end
                end
                default: d.st = DES_SEARCH;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q        <= '0;
            q.st     <= DES_SLEEP;
            q.lock_n <= 1'b1;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // =========================================================================
    // Outputs
    // =========================================================================
    // A pending word is dropped rather than shown once lock is gone.
    assign parallel_data_out  = q.word;
    assign data_oe            = receive_output_enable & (q.st == DES_LOCKED);
    assign recovered_clock    = q.rclk;
    assign recovered_clock_oe = data_oe;
    assign rx_word_valid      = q.word_valid & ~q.lock_n;
    assign lock_n             = q.lock_n;
    assign false_lock_suspect = (q.st == DES_HOLD);
endmodule : rlk_des

`default_nettype wire

/* test/rlk_asserts.sv */
/* Checker for the link: line framing, serializer sleep and wake-up length,
   deserializer lock indicator and output enables.
   Assumes one clock with clk_en held high by the bench. */
`timescale 1ns/1ps
`default_nettype none

module rlk_asserts (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ser_line_out,
    input wire logic ser_line_oe,
    input wire logic line_level,
    input wire logic line_driver_enable,
    input wire logic sleep_request_n,
    input wire logic receive_output_enable,
    input wire logic tx_running,
    input wire logic lock_n,
    input wire logic data_oe,
    input wire logic recovered_clock_oe,
    input wire logic rx_word_valid,
    input wire logic false_lock_suspect
);
    // ==========================================================
    // Run-length and wake-up counters
    // ==========================================================
    // The wake-up window allows edge bookkeeping but is no wider than one frame (12 cycles).
    localparam int INIT_LO = 6115;
    localparam int INIT_HI = 6127;
    logic [3:0]  ones_q;
    logic [3:0]  zeros_q;
    logic [12:0] init_q;
    logic        hi;
    logic        lo;
    logic        waking;

    assign hi     = ser_line_oe && ser_line_out;
    assign lo     = ser_line_oe && !ser_line_out;
    assign waking = sleep_request_n && !tx_running;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ones_q  <= 4'h0;
            zeros_q <= 4'h0;
            init_q  <= 13'h0000;
        end else begin
            ones_q  <= hi ? ones_q + {3'h0, ones_q != 4'hF} : 4'h0;
            zeros_q <= lo ? zeros_q + {3'h0, zeros_q != 4'hF} : 4'h0;
            init_q  <= waking ? init_q + {12'h000, init_q != 13'h1FFF} : 13'h0000;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_release; !line_driver_enable |-> !ser_line_oe && !line_level; endproperty
    a_release: assert property (p_release) else $error("line driven while disabled");
    property p_ser_sleep; !sleep_request_n |=> !tx_running && !ser_line_oe; endproperty
    a_ser_sleep: assert property (p_ser_sleep) else $error("serializer awake");
    property p_init; $rose(tx_running) |-> init_q >= INIT_LO && init_q <= INIT_HI; endproperty
    a_init: assert property (p_init) else $error("wake-up length wrong");
    property p_ones; ones_q <= 4'hB; endproperty
    a_ones: assert property (p_ones) else $error("too many ones on line");
    property p_zeros; zeros_q <= 4'hB; endproperty
    a_zeros: assert property (p_zeros) else $error("too many zeros on line");
    property p_out_off; !receive_output_enable |-> !data_oe && !recovered_clock_oe; endproperty
    a_out_off: assert property (p_out_off) else $error("outputs driven while off");
    property p_loss; $rose(lock_n) |-> !data_oe && !recovered_clock_oe; endproperty
    a_loss: assert property (p_loss) else $error("outputs driven after loss");
    property p_valid; rx_word_valid |-> !lock_n; endproperty
    a_valid: assert property (p_valid) else $error("word valid while unlocked");
    property p_hold; false_lock_suspect |-> lock_n; endproperty
    a_hold: assert property (p_hold) else $error("lock shown on suspect pattern");
    property p_des_sleep;
        !sleep_request_n && !receive_output_enable |=> (lock_n && !data_oe) [*2];
    endproperty
    a_des_sleep: assert property (p_des_sleep) else $error("receiver awake");

    c_lock: cover property ($fell(lock_n));
    c_hold: cover property ($rose(false_lock_suspect));
    c_run: cover property ($rose(tx_running));
    c_word: cover property (rx_word_valid && data_oe);
endmodule : rlk_asserts

`default_nettype wire

/* test/tb_top.sv */
/* Bench for the link: both ends joined by the link interface, user ports
   driven at the falling clock edge. Assumes package and interface first. */
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import rlk_pkg::*;
;
    logic                    sys_clk = 1'h0;
    logic                    sys_rst;
    logic                    clk_en;
    logic [PAYLOAD_BITS-1:0] parallel_data_in;
    logic [PAYLOAD_BITS-1:0] parallel_data_out;
    logic                    in_valid;
    logic                    in_ready;
    logic                    pattern_request_a;
    logic                    pattern_request_b;
    logic                    transmit_edge_select;
    logic                    sleep_request_n;
    logic                    line_driver_enable;
    logic                    receive_output_enable;
    logic                    tx_running;
    logic                    data_oe;
    logic                    recovered_clock_oe;
    logic                    rx_word_valid;
    logic                    lock_n;
    logic                    false_lock_suspect;
    logic [PAYLOAD_BITS-1:0] got [$];
    logic [PAYLOAD_BITS-1:0] wl [8] = '{10'h155, 10'h2AA, 10'h000, 10'h0F0,
                                        10'h3FF, 10'h30F, 10'h155, 10'h2AA};
    int                      errors = 0;
    int                      n_compared = 0;
    int                      i;
    int                      k;

    always #5 sys_clk = ~sys_clk;

    rlk_link_if link_if ();
    rlk_ser rlk_ser_inst (.sys_clk, .sys_rst, .clk_en, .link(link_if), .parallel_data_in,
        .in_valid, .in_ready, .pattern_request_a, .pattern_request_b, .transmit_edge_select,
        .sleep_request_n, .line_driver_enable, .tx_running);
    rlk_des rlk_des_inst (.sys_clk, .sys_rst, .clk_en, .link(link_if), .sleep_request_n,
        .receive_output_enable, .parallel_data_out, .data_oe, .recovered_clock(),
        .recovered_clock_oe, .rx_word_valid, .lock_n, .false_lock_suspect);
    rlk_asserts rlk_asserts_inst (.sys_clk, .sys_rst, .ser_line_out(link_if.ser_line_out),
        .ser_line_oe(link_if.ser_line_oe), .line_level(link_if.line_level),
        .line_driver_enable, .sleep_request_n, .receive_output_enable, .tx_running, .lock_n,
        .data_oe, .recovered_clock_oe, .rx_word_valid, .false_lock_suspect);

    // ==========================================================
    // Monitor and tasks
    // ==========================================================
    // Sync words are filler between data, so only payload words are kept.
    always @(negedge sys_clk) begin
        if (rx_word_valid === 1'h1 && parallel_data_out !== SYNC_PAYLOAD) begin
            got.push_back(parallel_data_out);
        end
    end

    task automatic chk_bit(input logic g, input logic e, input string what);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t %s: got %b want %b", $time, what, g, e);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [PAYLOAD_BITS-1:0] g, input logic [PAYLOAD_BITS-1:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t word: got %h want %h", $time, g, e);
        end
    endtask : chk_word

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    // The word is held until a falling edge sees room, then taken at the next rise.
    task automatic put_word(input logic [PAYLOAD_BITS-1:0] w);
        int t;
        parallel_data_in = w;
        in_valid = 1'h1;
        for (t = 0; t < 4000 && in_ready !== 1'h1; t++) cyc(1);
        cyc(1);
        in_valid = 1'h0;
        cyc(1);
    endtask : put_word

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (80000) @(posedge sys_clk);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        sys_rst = 1'h1;
        clk_en = 1'h1;
        parallel_data_in = 10'h000;
        in_valid = 1'h0;
        pattern_request_a = 1'h0;
        pattern_request_b = 1'h0;
        transmit_edge_select = 1'h0;
        sleep_request_n = 1'h0;
        line_driver_enable = 1'h1;
        receive_output_enable = 1'h0;
        cyc(16);
        sys_rst = 1'h0;
        cyc(1);
        chk_bit(lock_n, 1'h1, "lock after reset");
        chk_bit(tx_running, 1'h0, "run after reset");
        sleep_request_n = 1'h1;
        receive_output_enable = 1'h1;
        pattern_request_a = 1'h1;
        cyc(2);
        chk_bit(lock_n, 1'h1, "lock before frames");
        for (i = 0; i < 6000 && lock_n !== 1'h0; i++) cyc(1);
        chk_bit(lock_n, 1'h0, "lock in wake-up");
        chk_bit(tx_running, 1'h0, "still waking");
        for (i = 0; i < 6300 && tx_running !== 1'h1; i++) cyc(1);
        chk_bit(tx_running, 1'h1, "wake-up done");
        $display("test wake done");

        got.delete();
        for (i = 0; i < 8; i++) put_word(wl[i]);
        chk_bit(in_ready, 1'h0, "fifo full");
        pattern_request_a = 1'h0;
        for (i = 0; i < 8; i++) put_word(wl[7 - i]);
        cyc(300);
        for (i = 0; i < 16; i++) chk_word(got[i], wl[i < 8 ? i : 15 - i]);
        $display("test data done");

        for (k = 0; k < 9; k++) begin
            put_word(10'h000);
            cyc(48);
            put_word(10'h001 << (k + 1));
            cyc(24);
            line_driver_enable = 1'h0;
            cyc(36);
            chk_bit(lock_n, 1'h1, "lock lost");
            chk_bit(data_oe, 1'h0, "data released");
            chk_bit(tx_running, 1'h1, "run kept");
            line_driver_enable = 1'h1;
            for (i = 0; i < 240 && false_lock_suspect !== 1'h1; i++) cyc(1);
            chk_bit(false_lock_suspect, 1'h1, "suspect seen");
            cyc(120);
            chk_bit(lock_n, 1'h1, "lock held off");
            put_word(10'h000);
            for (i = 0; i < 360 && lock_n !== 1'h0; i++) cyc(1);
            chk_bit(lock_n, 1'h0, "relock");
            chk_bit(false_lock_suspect, 1'h0, "suspect gone");
        end
        $display("test false lock done");

        receive_output_enable = 1'h0;
        cyc(36);
        chk_bit(data_oe, 1'h0, "data off");
        chk_bit(recovered_clock_oe, 1'h0, "clock off");
        chk_bit(lock_n, 1'h0, "lock still shown");
        receive_output_enable = 1'h1;
        cyc(2);
        chk_bit(data_oe, 1'h1, "data on");
        $display("test output enable done");

        line_driver_enable = 1'h0;
        cyc(1);
        transmit_edge_select = 1'h1;
        cyc(11);
        line_driver_enable = 1'h1;
        cyc(2);
        chk_bit(tx_running, 1'h0, "restart");
        for (i = 0; i < 6300 && tx_running !== 1'h1; i++) cyc(1);
        chk_bit(tx_running, 1'h1, "restart done");
        $display("test restart done");

        sleep_request_n = 1'h0;
        cyc(2);
        chk_bit(tx_running, 1'h0, "ser asleep");
        chk_bit(link_if.ser_line_oe, 1'h0, "line released");
        cyc(48);
        chk_bit(lock_n, 1'h1, "lock lost asleep");
        receive_output_enable = 1'h0;
        cyc(2);
        chk_bit(data_oe, 1'h0, "des asleep");
        got.delete();
        sleep_request_n = 1'h1;
        receive_output_enable = 1'h1;
        cyc(2);
        chk_bit(lock_n, 1'h1, "no early lock");
        for (i = 0; i < 6000 && lock_n !== 1'h0; i++) cyc(1);
        chk_bit(lock_n, 1'h0, "lock after wake");
        put_word(10'h3FF);
        for (i = 0; i < 6300 && tx_running !== 1'h1; i++) cyc(1);
        cyc(48);
        chk_word(got[0], 10'h3FF);
        $display("test sleep done");
        close_out();
    end
endmodule : tb_top

`default_nettype wire
